/* drb_reply_builder.sv */
// Discovery reply builder: streams the capability reply byte by byte.
`timescale 1ns/1ns
`include "drb_consts.svh"

// What this block does
// [RULE_01] Reply always leaves from UDP port 1024.
// [RULE_02] Reply goes to the requester's source port.
// [RULE_03] Bytes 0 to 3 are zero.
// [RULE_04] Byte 4 is 02, or 03 if owned elsewhere.
// [RULE_05] Bytes 5 to 10 carry MAC, high first.
// [RULE_06] Byte 12 is protocol version, unsigned.
// [RULE_07] Byte 13 is logic code version, unsigned.
// [RULE_08] Bytes 14 to 19 carry board versions.
// [RULE_09] Bytes 20 to 26 are bit-0 feature flags.
// [RULE_10] Bytes 27 to 30 carry clock frequency.
// [RULE_11] Bytes 36 to 39 describe ADCs and down-converters.
// [RULE_12] Bytes 40, 41 flag phase word, attenuator.
// [RULE_13] Bytes 42 to 50 describe wideband capture.
// [RULE_14] Byte 51 flag, bytes 52 to 55 rates.
// [RULE_15] Byte 56 flag, bytes 57, 58 counts.
// [RULE_16] Byte 59 gives receive codec mode.
// [RULE_17] Bytes 60 to 64 describe receive audio.
// [RULE_18] Bytes 70 to 77 describe transmit audio.
// [RULE_19] Byte 78 flags transmit phase word.
// [RULE_20] Bytes 79 to 82 describe transmit samples.
// [RULE_21] Bytes 83 to 87 flag amplifier and CW.
// [RULE_22] Bytes 88 to 96 hang, delay, outputs, calibration.
// [RULE_23] Multi-byte fields high first, flag spares zero.
// [RULE_24] Reserved bytes zero; reply only on request.
module drb_reply_builder (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Discovery request from the command receiver.
  input wire logic disc_req,
  input wire logic [15:0] disc_src_port,
  input wire logic [31:0] disc_src_ip,
  // Connection state of the radio.
  input wire logic run_active,
  input wire logic [31:0] owner_ip,
  // Reply header toward the UDP sender.
  output logic tx_start,
  output logic [15:0] tx_src_port,
  output logic [15:0] tx_dst_port,
  output logic [31:0] tx_dst_ip,
  // Reply byte stream.
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] ctrl;
  logic [31:0] mac_hi;
  logic [31:0] mac_lo;
  logic [31:0] vers;
  logic [31:0] boards0;
  logic [31:0] boards1;
  logic [31:0] flags;
  logic [31:0] dsp_clk;
  logic [31:0] rx_counts;
  logic [31:0] wideband;
  logic [31:0] rx_audio;
  logic [31:0] ddc_rates;
  logic [31:0] rx_pkt;
  logic [31:0] tx_audio;
  logic [31:0] tx_sizes;
  logic [31:0] cw_misc;
  logic [31:0] cal;
  logic [15:0] reply_count;
  drb_pkg::drb_state_t state;
  logic [10:0] cur_idx;
  logic [7:0] reply_code;
  logic req_take;
  logic beat;
  logic [10:0] next_idx;

  assign req_take = (state == drb_pkg::DRB_IDLE) && disc_req &&
                    ctrl[`DRB_CTRL_ENABLE];
  assign beat = tx_valid && tx_ready;
  assign next_idx = cur_idx + 11'h001;

  // Software writes load the capability fields.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DRB_CTRL_RESET;
      mac_hi <= `DRB_CAP_RESET;
      mac_lo <= `DRB_CAP_RESET;
      vers <= `DRB_VERS_RESET;
      boards0 <= `DRB_CAP_RESET;
      boards1 <= `DRB_CAP_RESET;
      flags <= `DRB_CAP_RESET;
      dsp_clk <= `DRB_CAP_RESET;
      rx_counts <= `DRB_CAP_RESET;
      wideband <= `DRB_CAP_RESET;
      rx_audio <= `DRB_CAP_RESET;
      ddc_rates <= `DRB_CAP_RESET;
      rx_pkt <= `DRB_CAP_RESET;
      tx_audio <= `DRB_CAP_RESET;
      tx_sizes <= `DRB_CAP_RESET;
      cw_misc <= `DRB_CAP_RESET;
      cal <= `DRB_CAP_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `DRB_OFS_CTRL: ctrl <= {31'h0, reg_wdata[0]};
        `DRB_OFS_MAC_HI: mac_hi <= {16'h0, reg_wdata[15:0]};
        `DRB_OFS_MAC_LO: mac_lo <= reg_wdata;
        `DRB_OFS_VERS: vers <= {8'h0, reg_wdata[23:0]};
        `DRB_OFS_BOARDS0: boards0 <= reg_wdata;
        `DRB_OFS_BOARDS1: boards1 <= {16'h0, reg_wdata[15:0]};
        `DRB_OFS_FLAGS: flags <= {3'h0, reg_wdata[28:0]};
        `DRB_OFS_DSP_CLK: dsp_clk <= reg_wdata;
        `DRB_OFS_RX_COUNTS: rx_counts <= reg_wdata;
        `DRB_OFS_WIDEBAND: wideband <= reg_wdata;
        `DRB_OFS_RX_AUDIO: rx_audio <= reg_wdata;
        `DRB_OFS_DDC_RATES: ddc_rates <= reg_wdata;
        `DRB_OFS_RX_PKT: rx_pkt <= reg_wdata;
        `DRB_OFS_TX_AUDIO: tx_audio <= reg_wdata;
        `DRB_OFS_TX_SIZES: tx_sizes <= reg_wdata;
        `DRB_OFS_CW_MISC: cw_misc <= reg_wdata;
        `DRB_OFS_CAL: cal <= {16'h0, reg_wdata[15:0]};
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `DRB_OFS_CTRL: reg_rdata <= ctrl;
        `DRB_OFS_MAC_HI: reg_rdata <= mac_hi;
        `DRB_OFS_MAC_LO: reg_rdata <= mac_lo;
        `DRB_OFS_VERS: reg_rdata <= vers;
        `DRB_OFS_BOARDS0: reg_rdata <= boards0;
        `DRB_OFS_BOARDS1: reg_rdata <= boards1;
        `DRB_OFS_FLAGS: reg_rdata <= flags;
        `DRB_OFS_DSP_CLK: reg_rdata <= dsp_clk;
        `DRB_OFS_RX_COUNTS: reg_rdata <= rx_counts;
        `DRB_OFS_WIDEBAND: reg_rdata <= wideband;
        `DRB_OFS_RX_AUDIO: reg_rdata <= rx_audio;
        `DRB_OFS_DDC_RATES: reg_rdata <= ddc_rates;
        `DRB_OFS_RX_PKT: reg_rdata <= rx_pkt;
        `DRB_OFS_TX_AUDIO: reg_rdata <= tx_audio;
        `DRB_OFS_TX_SIZES: reg_rdata <= tx_sizes;
        `DRB_OFS_CW_MISC: reg_rdata <= cw_misc;
        `DRB_OFS_CAL: reg_rdata <= cal;
        `DRB_OFS_STATUS: reg_rdata <= {15'h0,
            (state == drb_pkg::DRB_SEND), reply_count};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ************************************************************
  // Reply content
  // ************************************************************
  // Returns the reply byte at a given position.
  function automatic logic [7:0] byte_at(input logic [10:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      11'd4: b = reply_code; // [RULE_04]
      11'd5: b = mac_hi[15:8]; // [RULE_05]
      11'd6: b = mac_hi[7:0]; // [RULE_05]
      11'd7: b = mac_lo[31:24]; // [RULE_05]
      11'd8: b = mac_lo[23:16]; // [RULE_05]
      11'd9: b = mac_lo[15:8]; // [RULE_05]
      11'd10: b = mac_lo[7:0]; // [RULE_05]
      11'd11: b = vers[23:16];
      11'd12: b = vers[7:0]; // [RULE_06]
      11'd13: b = vers[15:8]; // [RULE_07]
      11'd14: b = boards0[31:24]; // [RULE_08]
      11'd15: b = boards0[23:16]; // [RULE_08]
      11'd16: b = boards0[15:8]; // [RULE_08]
      11'd17: b = boards0[7:0]; // [RULE_08]
      11'd18: b = boards1[15:8]; // [RULE_08]
      11'd19: b = boards1[7:0]; // [RULE_08]
      11'd20: b = {7'h0, flags[0]}; // [RULE_09] [RULE_23]
      11'd21: b = {7'h0, flags[1]}; // [RULE_09]
      11'd22: b = {7'h0, flags[2]}; // [RULE_09]
      11'd23: b = {7'h0, flags[3]}; // [RULE_09]
      11'd24: b = {7'h0, flags[4]}; // [RULE_09]
      11'd25: b = {7'h0, flags[5]}; // [RULE_09]
      11'd26: b = {7'h0, flags[6]}; // [RULE_09]
      11'd27: b = dsp_clk[31:24]; // [RULE_10] [RULE_23]
      11'd28: b = dsp_clk[23:16]; // [RULE_10]
      11'd29: b = dsp_clk[15:8]; // [RULE_10]
      11'd30: b = dsp_clk[7:0]; // [RULE_10]
      11'd36: b = rx_counts[7:0]; // [RULE_11]
      11'd37: b = {7'h0, flags[7]}; // [RULE_11]
      11'd38: b = {7'h0, flags[8]}; // [RULE_11]
      11'd39: b = rx_counts[15:8]; // [RULE_11]
      11'd40: b = {7'h0, flags[9]}; // [RULE_12]
      11'd41: b = {7'h0, flags[10]}; // [RULE_12]
      11'd42: b = {7'h0, flags[11]}; // [RULE_13]
      11'd43: b = wideband[15:8]; // [RULE_13]
      11'd44: b = wideband[7:0]; // [RULE_13]
      11'd45: b = {7'h0, flags[12]}; // [RULE_13]
      11'd46: b = wideband[23:16]; // [RULE_13]
      11'd47: b = {7'h0, flags[13]}; // [RULE_13]
      11'd48: b = wideband[31:24]; // [RULE_13]
      11'd49: b = {7'h0, flags[14]}; // [RULE_13]
      11'd50: b = rx_audio[7:0]; // [RULE_13]
      11'd51: b = {7'h0, flags[15]}; // [RULE_14]
      11'd52: b = ddc_rates[31:24]; // [RULE_14]
      11'd53: b = ddc_rates[23:16]; // [RULE_14]
      11'd54: b = ddc_rates[15:8]; // [RULE_14]
      11'd55: b = ddc_rates[7:0]; // [RULE_14]
      11'd56: b = {7'h0, flags[16]}; // [RULE_15]
      11'd57: b = rx_counts[23:16]; // [RULE_15]
      11'd58: b = rx_counts[31:24]; // [RULE_15]
      11'd59: b = rx_audio[15:8]; // [RULE_16]
      11'd60: b = rx_audio[23:16]; // [RULE_17]
      11'd61: b = rx_audio[31:24]; // [RULE_17]
      11'd62: b = rx_pkt[15:8]; // [RULE_17]
      11'd63: b = rx_pkt[7:0]; // [RULE_17]
      11'd64: b = {7'h0, flags[17]}; // [RULE_17]
      11'd70: b = rx_pkt[23:16]; // [RULE_18]
      11'd71: b = {7'h0, flags[18]}; // [RULE_18]
      11'd72: b = {7'h0, flags[19]}; // [RULE_18]
      11'd73: b = {7'h0, flags[20]}; // [RULE_18]
      11'd74: b = rx_pkt[31:24]; // [RULE_18]
      11'd75: b = tx_audio[7:0]; // [RULE_18]
      11'd76: b = tx_sizes[31:24]; // [RULE_18]
      11'd77: b = tx_sizes[23:16]; // [RULE_18]
      11'd78: b = {7'h0, flags[21]}; // [RULE_19]
      11'd79: b = tx_audio[15:8]; // [RULE_20]
      11'd80: b = tx_audio[23:16]; // [RULE_20]
      11'd81: b = tx_sizes[15:8]; // [RULE_20]
      11'd82: b = tx_sizes[7:0]; // [RULE_20]
      11'd83: b = {7'h0, flags[22]}; // [RULE_21]
      11'd84: b = {7'h0, flags[23]}; // [RULE_21]
      11'd85: b = {7'h0, flags[24]}; // [RULE_21]
      11'd86: b = {7'h0, flags[25]}; // [RULE_21]
      11'd87: b = {7'h0, flags[26]}; // [RULE_21]
      11'd88: b = cw_misc[31:24]; // [RULE_22]
      11'd89: b = cw_misc[23:16]; // [RULE_22]
      11'd90: b = tx_audio[31:24]; // [RULE_22]
      11'd91: b = {7'h0, flags[27]};
      11'd92: b = {7'h0, flags[28]};
      11'd93: b = cw_misc[15:8]; // [RULE_22]
      11'd94: b = cal[15:8]; // [RULE_22]
      11'd95: b = cal[7:0]; // [RULE_22]
      11'd96: b = cw_misc[7:0]; // [RULE_22]
      default: b = 8'h00; // [RULE_03] [RULE_24]
    endcase
    return b;
  endfunction

  // ************************************************************
  // Sequencer
  // ************************************************************
  // A request is taken only when idle and enabled; others are dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= drb_pkg::DRB_IDLE;
    end else begin
      case (state)
        drb_pkg::DRB_IDLE: begin
          if (req_take) begin // [RULE_24]
            state <= drb_pkg::DRB_SEND;
          end
        end
        drb_pkg::DRB_SEND: begin
          if (beat && tx_last) begin
            state <= drb_pkg::DRB_IDLE;
          end
        end
        default: state <= drb_pkg::DRB_IDLE;
      endcase
    end
  end

  // Header fields are caught with the request and held through the reply.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_src_port <= `DRB_SRC_PORT;
      tx_dst_port <= 16'h0;
      tx_dst_ip <= 32'h0;
      reply_code <= `DRB_CODE_IDLE;
      tx_start <= 1'b0;
    end else begin
      tx_start <= req_take;
      if (req_take) begin
        tx_src_port <= `DRB_SRC_PORT; // [RULE_01]
        tx_dst_port <= disc_src_port; // [RULE_02]
        tx_dst_ip <= disc_src_ip;
        reply_code <= (run_active && owner_ip != disc_src_ip) ?
                      `DRB_CODE_OTHER : `DRB_CODE_IDLE; // [RULE_04]
      end
    end
  end

  // Byte stream: one byte per accepted beat, high byte of a field first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      cur_idx <= 11'h0;
    end else if (req_take) begin
      tx_valid <= 1'b1;
      tx_data <= 8'h00; // [RULE_03]
      tx_last <= 1'b0;
      cur_idx <= 11'h0;
    end else if (beat) begin
      if (tx_last) begin
        tx_valid <= 1'b0;
        tx_data <= 8'h00;
        tx_last <= 1'b0;
        cur_idx <= 11'h0;
      end else begin
        tx_data <= byte_at(next_idx); // [RULE_23]
        tx_last <= (next_idx == `DRB_LAST_IDX);
        cur_idx <= next_idx;
      end
    end
  end

  // Counts completed replies for software.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_count <= 16'h0;
    end else if (beat && tx_last) begin
      reply_count <= reply_count + 16'h0001;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_request;
    req_take;
  endsequence
  sequence s_first_byte;
    tx_valid && cur_idx == 11'h0 && tx_data == 8'h00 && tx_start;
  endsequence

  a_source_port: assert property ( // [RULE_01]
    tx_valid |-> tx_src_port == `DRB_SRC_PORT)
    else $error("reply source port is not 1024");
  a_dest_port: assert property ( // [RULE_02]
    s_request |=> tx_dst_port == $past(disc_src_port))
    else $error("reply destination port not requester port");
  a_dest_hold: assert property ( // [RULE_02]
    !req_take |=> $stable(tx_dst_port))
    else $error("reply destination port changed without request");
  a_seq_zero: assert property ( // [RULE_03]
    tx_valid && cur_idx < 11'd4 |-> tx_data == 8'h00)
    else $error("sequence number byte not zero");
  a_reply_code: assert property ( // [RULE_04]
    s_request |=> reply_code == (($past(run_active) &&
      $past(owner_ip) != $past(disc_src_ip)) ?
      `DRB_CODE_OTHER : `DRB_CODE_IDLE))
    else $error("reply code not taken from connection state");
  a_code_byte: assert property ( // [RULE_04]
    tx_valid && cur_idx == 11'd4 |-> tx_data == reply_code)
    else $error("reply code byte wrong");
  a_mac_first: assert property ( // [RULE_05]
    tx_valid && cur_idx == 11'd5 |-> tx_data == mac_hi[15:8])
    else $error("MAC high byte not first");
  a_proto_vers: assert property ( // [RULE_06]
    tx_valid && cur_idx == 11'd12 |-> tx_data == vers[7:0])
    else $error("protocol version byte wrong");
  a_clock_high: assert property ( // [RULE_10]
    tx_valid && cur_idx == 11'd27 |-> tx_data == dsp_clk[31:24])
    else $error("clock frequency not high byte first");
  a_flag_spare: assert property ( // [RULE_23]
    tx_valid && cur_idx inside {[11'd20:11'd26]} |-> tx_data[7:1] == 7'h0)
    else $error("flag byte spare bits set");
  a_reserved_zero: assert property ( // [RULE_24]
    tx_valid && cur_idx >= `DRB_FIRST_FREE |-> tx_data == 8'h00)
    else $error("future-use byte not zero");
  a_reply_start: assert property ( // [RULE_24]
    s_request |=> s_first_byte)
    else $error("reply did not start after request");
  a_no_spont: assert property ( // [RULE_24]
    $rose(tx_valid) |-> $past(req_take))
    else $error("reply sent without a request");
  a_last_byte: assert property ( // [RULE_23]
    tx_valid && tx_last |-> cur_idx == `DRB_LAST_IDX)
    else $error("last marker on wrong byte");
endmodule

/* drb_consts.svh */
// Offsets, field positions, reset values and fixed figures of the reply builder.
`ifndef DRB_CONSTS_SVH
`define DRB_CONSTS_SVH

// ************************************************************
// Reply framing
// ************************************************************
`define DRB_SRC_PORT 16'h0400
`define DRB_CODE_IDLE 8'h02
`define DRB_CODE_OTHER 8'h03
`define DRB_REPLY_LEN 11'h5A0
`define DRB_LAST_IDX 11'h59F
`define DRB_FIRST_FREE 11'h061

// ************************************************************
// Register offsets (word aligned)
// ************************************************************
`define DRB_OFS_CTRL 8'h00
`define DRB_OFS_MAC_HI 8'h04
`define DRB_OFS_MAC_LO 8'h08
`define DRB_OFS_VERS 8'h0C
`define DRB_OFS_BOARDS0 8'h10
`define DRB_OFS_BOARDS1 8'h14
`define DRB_OFS_FLAGS 8'h18
`define DRB_OFS_DSP_CLK 8'h1C
`define DRB_OFS_RX_COUNTS 8'h20
`define DRB_OFS_WIDEBAND 8'h24
`define DRB_OFS_RX_AUDIO 8'h28
`define DRB_OFS_DDC_RATES 8'h2C
`define DRB_OFS_RX_PKT 8'h30
`define DRB_OFS_TX_AUDIO 8'h34
`define DRB_OFS_TX_SIZES 8'h38
`define DRB_OFS_CW_MISC 8'h3C
`define DRB_OFS_CAL 8'h40
`define DRB_OFS_STATUS 8'h44

// ************************************************************
// Field positions and reset values
// ************************************************************
`define DRB_CTRL_ENABLE 0
`define DRB_CTRL_RESET 32'h0000_0001
`define DRB_VERS_RESET 32'h00FF_0000
`define DRB_CAP_RESET 32'h0000_0000

`endif

/* drb_pkg.sv */
// Types shared by the reply builder.
package drb_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    DRB_IDLE = 2'b01,
    DRB_SEND = 2'b10
  } drb_state_t;

endpackage

/* drb_host_sink.sv */
// Host-side sink that takes reply bytes, records them and can stall.
`timescale 1ns/1ns

module drb_host_sink (
  // Clock.
  input wire logic clk,
  // Reply stream from the builder.
  input wire logic tx_start,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // Stall control from the bench.
  input wire logic slow,
  output logic tx_ready
);
  logic [7:0] got [0:1439];
  int n_got = 0;
  int n_starts = 0;
  int last_idx = -1;
  int hold_err = 0;
  logic [1:0] phase = 2'h0;
  logic [7:0] held = 8'h00;
  logic waiting = 1'b0;

  initial tx_ready = 1'b1;

  // Ready is high one cycle in three when slow, else always high.
  always @(posedge clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    tx_ready <= !slow || (phase == 2'h1);
  end

  // Bytes are kept raw; versions are decoded later by software.
  always @(posedge clk) begin : take
    int i;
    i = tx_start ? 0 : n_got;
    if (tx_start) begin
      n_starts = n_starts + 1;
      n_got = 0;
    end
    if (waiting && (!tx_valid || tx_data !== held)) begin
      hold_err = hold_err + 1;
    end
    if (tx_valid && tx_ready && i < 1440) begin
      got[i] = tx_data;
      if (tx_last) begin
        last_idx = i;
      end
      n_got = i + 1;
    end
    waiting = tx_valid && !tx_ready;
    held = tx_data;
  end
endmodule

/* tb.sv */
// Self-checking bench for the discovery reply builder.
`timescale 1ns/1ns

module tb;
  logic clk, rst_n, reg_wr, reg_rd, disc_req, run_active, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, disc_src_ip, owner_ip, tx_dst_ip;
  logic [15:0] disc_src_port, tx_src_port, tx_dst_port;
  logic tx_start, tx_valid, tx_last, tx_ready;
  logic [7:0] tx_data;
  logic [7:0] exp [0:96];
  logic [31:0] rv [0:16];
  int mismatches = 0;
  int n_tests = 0;
  int n_done = 0;
  localparam int FPOS [0:28] = '{20, 21, 22, 23, 24, 25, 26, 37, 38, 40,
    41, 42, 45, 47, 49, 51, 56, 64, 71, 72, 73, 78, 83, 84, 85, 86, 87,
    91, 92};

  drb_reply_builder i_drb_reply_builder (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disc_req(disc_req),
    .disc_src_port(disc_src_port), .disc_src_ip(disc_src_ip),
    .run_active(run_active), .owner_ip(owner_ip), .tx_start(tx_start),
    .tx_src_port(tx_src_port), .tx_dst_port(tx_dst_port),
    .tx_dst_ip(tx_dst_ip), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  drb_host_sink i_drb_host_sink (.clk(clk), .tx_start(tx_start),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .slow(slow), .tx_ready(tx_ready));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand one cycle only, then drop to zero.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), e, reg_rdata);
    @(negedge clk);
    chk("rdata idle", 32'h0000_0000, reg_rdata);
  endtask

  task automatic disc(input logic [15:0] p, input logic [31:0] ip);
    @(posedge clk);
    disc_req <= 1'b1;
    disc_src_port <= p;
    disc_src_ip <= ip;
    @(posedge clk);
    disc_req <= 1'b0;
  endtask

  // Expected capability bytes from the register image.
  task automatic mk_exp(input logic [7:0] code);
    for (int i = 0; i < 97; i++) begin
      exp[i] = 8'h00;
    end
    exp[4] = code;
    {exp[5], exp[6]} = rv[1][15:0];
    {exp[7], exp[8], exp[9], exp[10]} = rv[2];
    {exp[11], exp[13], exp[12]} = rv[3][23:0];
    {exp[14], exp[15], exp[16], exp[17]} = rv[4];
    {exp[18], exp[19]} = rv[5][15:0];
    for (int i = 0; i < 29; i++) begin
      exp[FPOS[i]] = {7'h00, rv[6][i]};
    end
    {exp[27], exp[28], exp[29], exp[30]} = rv[7];
    {exp[58], exp[57], exp[39], exp[36]} = rv[8];
    {exp[48], exp[46], exp[43], exp[44]} = rv[9];
    {exp[61], exp[60], exp[59], exp[50]} = rv[10];
    {exp[52], exp[53], exp[54], exp[55]} = rv[11];
    {exp[74], exp[70], exp[62], exp[63]} = rv[12];
    {exp[90], exp[80], exp[79], exp[75]} = rv[13];
    {exp[76], exp[77], exp[81], exp[82]} = rv[14];
    {exp[88], exp[89], exp[93], exp[96]} = rv[15];
    {exp[94], exp[95]} = rv[16][15:0];
  endtask

  task automatic cmp_rng(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      chk($sformatf("byte %0d", i), (i < 97) ? exp[i] : 8'h00,
          i_drb_host_sink.got[i]);
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    @(negedge clk);
    chk("src port", 32'h0000_0400, tx_src_port);
    chk("valid", 32'h0, tx_valid);
    for (int k = 0; k < 18; k++) begin
      rd(8'(k * 4), (k == 0) ? 32'h1 : (k == 3) ? 32'h00FF_0000 : 32'h0);
    end
    rd(8'h48, 32'h0);
  endtask

  task automatic t_regs();
    for (int k = 0; k < 17; k++) begin
      wr(8'(k * 4), rv[k]);
    end
    wr(8'h48, 32'hFFFF_FFFF);
    wr(8'h44, 32'hFFFF_FFFF);
    for (int k = 0; k < 17; k++) begin
      rd(8'(k * 4), rv[k]);
    end
    rd(8'h48, 32'h0);
    rd(8'h44, 32'h0);
  endtask

  // One reply; optionally a second request is sent while it streams.
  task automatic t_reply(input logic [15:0] p, input logic [31:0] ip,
      input logic run, input logic [31:0] own, input logic [7:0] code,
      input logic slw, input logic intr);
    int s0;
    int w;
    s0 = i_drb_host_sink.n_starts;
    @(posedge clk);
    run_active <= run;
    owner_ip <= own;
    slow <= slw;
    mk_exp(code);
    disc(p, ip);
    @(negedge clk);
    chk("start", 32'h1, tx_start);
    chk("src port", 32'h0000_0400, tx_src_port);
    chk("dst port", p, tx_dst_port);
    chk("dst ip", ip, tx_dst_ip);
    if (intr) begin
      disc(p + 16'h0001, ip + 32'h1);
      rd(8'h44, {15'h0, 1'b1, 16'(n_done)});
    end
    w = 0;
    while (!(i_drb_host_sink.n_got == 1440 && tx_valid === 1'b0)) begin
      @(negedge clk);
      w++;
      if (w > 6000) begin
        chk("reply done", 32'h1, 32'h0);
        stop_test();
      end
    end
    n_done++;
    chk("starts", s0 + 1, i_drb_host_sink.n_starts);
    chk("dst held", p, tx_dst_port);
    chk("last index", 1439, i_drb_host_sink.last_idx);
    chk("hold", 0, i_drb_host_sink.hold_err);
    cmp_rng(0, 4);
    cmp_rng(5, 19);
    cmp_rng(20, 35);
    cmp_rng(36, 55);
    cmp_rng(56, 69);
    cmp_rng(70, 82);
    cmp_rng(83, 1439);
  endtask

  // A disabled builder drops requests silently.
  task automatic t_disabled();
    int s0;
    s0 = i_drb_host_sink.n_starts;
    wr(8'h00, 32'h0);
    disc(16'h1234, 32'h0A00_0005);
    repeat (5) @(negedge clk);
    chk("no start", s0, i_drb_host_sink.n_starts);
    chk("idle", 32'h0, tx_valid);
    wr(8'h00, 32'h1);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    disc_req = 1'b0;
    disc_src_port = 16'h0;
    disc_src_ip = 32'h0;
    run_active = 1'b0;
    owner_ip = 32'h0;
    slow = 1'b0;
    rv = '{32'h0000_0001, 32'h0000_A1B2, 32'hC3D4_E5F6, 32'h00FF_0F68,
      32'h1122_3344, 32'h0000_5566, 32'h0AAA_AAAA, 32'h07A1_2000,
      32'h0403_0201, 32'h2118_0ABC, 32'h1030_0205, 32'h0030_0600,
      32'h3001_0168, 32'hFF18_C010, 32'h02D0_00F0, 32'h03E8_0706,
      32'h0000_ABCD};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_reply(16'hC350, 32'hC0A8_0102, 1'b0, 32'h0, 8'h02, 1'b0, 1'b0);
    wr(8'h18, 32'h1555_5555);
    rv[6] = 32'h1555_5555;
    t_reply(16'h0401, 32'hC0A8_0103, 1'b1, 32'hC0A8_0109, 8'h03, 1'b1,
            1'b1);
    t_reply(16'hFFFF, 32'hC0A8_0109, 1'b1, 32'hC0A8_0109, 8'h02, 1'b0,
            1'b0);
    t_disabled();
    rd(8'h44, 32'h0000_0003);
    stop_test();
  end
endmodule
